/* File: rtl/sfsr_record.sv */
module sfsr_record #(
  parameter int BANK_IDX_W    = 8,
  parameter bit TWO_STAGE_FAULT_FLAG_SUPP   = 1'b1,
  parameter bit LEGACY_FMT    = 1'b0,
  parameter bit GRAN_4K       = 1'b1,
  parameter bit GRAN_16K      = 1'b0,
  parameter bit GRAN_64K      = 1'b0,
  parameter int ADDR_W        = 48
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rstn,
  // avalon-mm slave
  input  wire logic [4:0]            i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // fault recording event from the translation engine
  input  wire logic                  i_rec_valid,
  input  wire sfsr_pkg::sfsr_kind_type i_rec_kind,
  input  wire logic                  i_rec_two_stage_fault_flag,
  input  wire logic [7:0]            i_rec_bank_idx,
  input  wire logic                  i_rec_async,
  input  wire logic                  i_rec_in_walk,
  input  wire logic                  i_rec_addr_op,
  input  wire logic                  i_rec_nonsecure,
  input  wire logic                  i_rec_instr,
  input  wire logic                  i_rec_priv,
  input  wire logic                  i_rec_write,
  input  wire logic                  i_rec_atomic,
  input  wire logic                  i_rec_miss_rd,
  input  wire logic                  i_rec_miss_wr,
  input  wire logic                  i_rec_s1_walk,
  input  wire logic                  i_rec_perm_fault,
  input  wire logic [1:0]            i_rec_level,
  input  wire logic [63:0]           i_rec_ipa,
  input  wire logic [63:0]           i_far,
  output logic                       o_rec_valid,
  output logic                       o_ipa_valid
);

  // =====================================================================
  // configuration checks and derived constants
  localparam int LOW_N = (LEGACY_FMT || GRAN_4K) ? sfsr_pkg::LOW_4K :
                         GRAN_16K ? sfsr_pkg::LOW_16K : sfsr_pkg::LOW_64K;

  if (BANK_IDX_W < 1 || BANK_IDX_W > sfsr_pkg::BIX_FULL_W)
  begin : g_bad_idx
    $error("bank index width out of range");
  end
  if (ADDR_W <= LOW_N || ADDR_W > 64)
  begin : g_bad_addr
    $error("address width out of range");
  end
  if (!LEGACY_FMT && !GRAN_4K && !GRAN_16K && !GRAN_64K)
  begin : g_bad_gran
    $error("no granule supported");
  end

  // mask of implemented fault address bits [ADDR_W-1:LOW_N]
  function automatic logic [63:0] faulting_ipa_field_mask();
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++)
    begin
      m[i] = (i >= LOW_N) && (i < ADDR_W);
    end
    return m;
  endfunction

  localparam logic [63:0] FAULTING_IPA_FIELD_MASK = faulting_ipa_field_mask();

  // byte-enable merge of a write into a 32-bit word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // writable bits of syndrome 0
  localparam logic [31:0] SYND0_WMASK =
    (TWO_STAGE_FAULT_FLAG_SUPP ? (32'h0000_00ff << sfsr_pkg::BIX_LSB) : 32'h0000_0000) |
    (32'h0000_0001 << sfsr_pkg::POS_ASYNC) | (32'h0000_0001 << sfsr_pkg::POS_WALK_EXT) |
    (32'h0000_0001 << sfsr_pkg::POS_ADDR_OP) | (32'h0000_0001 << sfsr_pkg::POS_NONSEC) |
    (32'h0000_0001 << sfsr_pkg::POS_INSTR) | (32'h0000_0001 << sfsr_pkg::POS_PRIV) |
    (32'h0000_0001 << sfsr_pkg::POS_WRITE) |
    (TWO_STAGE_FAULT_FLAG_SUPP ? ((32'h0000_0001 << sfsr_pkg::POS_S1_WALK) |
                    (32'h0000_0001 << sfsr_pkg::POS_TWO_STAGE_FAULT_FLAG)) : 32'h0000_0000) |
    32'h0000_0003;

  // stored part of the bank index field
  localparam logic [31:0] BIX_KEEP = ((32'h0000_0001 << BANK_IDX_W) - 32'h0000_0001) << sfsr_pkg::BIX_LSB;

  // =====================================================================
  // bus decode
  logic        ack_q;
  logic        req;
  logic        wr_fire;
  logic        rd_fire;
  logic        rec_en_q;
  logic [31:0] synd0_q;
  logic [31:0] synd1_q;
  logic [63:0] ipa_q;
  logic        rec_valid_q;
  logic        ipa_valid_q;
  logic [31:0] synd0_d;
  logic        rec_fire;
  logic        ipa_ok;
  logic        wr_flag;
  logic [63:0] ipa_view;

  assign req               = i_avs_read | i_avs_write;
  // one wait state: the answer is ready on the second cycle of a request
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_fire           = i_avs_write & ack_q;
  assign rd_fire           = i_avs_read & ~ack_q;
  assign rec_fire          = i_rec_valid & rec_en_q;

  // acknowledge flag, drops after the accepting edge so requests can follow back to back
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
    end
  end

  // =====================================================================
  // assembling a new syndrome from a record event
  always_comb
  begin
    // atomics report the missing permission, read when both or none is missing
    if (i_rec_atomic)
    begin
      wr_flag = i_rec_miss_wr & ~i_rec_miss_rd;
    end
    else
    begin
      wr_flag = i_rec_write;
    end
    synd0_d = sfsr_pkg::RST_SYND;
    if (TWO_STAGE_FAULT_FLAG_SUPP && i_rec_two_stage_fault_flag)
    begin
      synd0_d[sfsr_pkg::BIX_LSB +: 8] = i_rec_bank_idx;
    end
    synd0_d = synd0_d & (BIX_KEEP | ~(32'h0000_00ff << sfsr_pkg::BIX_LSB));
    synd0_d[sfsr_pkg::POS_ASYNC]    = i_rec_async;
    synd0_d[sfsr_pkg::POS_WALK_EXT] = i_rec_in_walk & (i_rec_kind == sfsr_pkg::FK_EXTERNAL);
    synd0_d[sfsr_pkg::POS_ADDR_OP]  = i_rec_addr_op;
    synd0_d[sfsr_pkg::POS_NONSEC]   = i_rec_nonsecure;
    synd0_d[sfsr_pkg::POS_INSTR]    = i_rec_instr;
    synd0_d[sfsr_pkg::POS_PRIV]     = i_rec_priv;
    synd0_d[sfsr_pkg::POS_WRITE]    = wr_flag;
    synd0_d[sfsr_pkg::POS_S1_WALK]  = TWO_STAGE_FAULT_FLAG_SUPP & i_rec_s1_walk;
    synd0_d[sfsr_pkg::POS_TWO_STAGE_FAULT_FLAG]   = TWO_STAGE_FAULT_FLAG_SUPP & i_rec_two_stage_fault_flag;
    synd0_d[sfsr_pkg::LVL_LSB +: sfsr_pkg::LVL_W] = i_rec_level;
  end

  // ipa validity for the fault kind being recorded
  always_comb
  begin
    unique case (i_rec_kind)
      sfsr_pkg::FK_TRANSLATION,
      sfsr_pkg::FK_ACCESS,
      sfsr_pkg::FK_EXTERNAL,
      sfsr_pkg::FK_ADDR_SIZE: ipa_ok = 1'b1;
      sfsr_pkg::FK_PERMISSION: ipa_ok = i_rec_perm_fault & TWO_STAGE_FAULT_FLAG_SUPP & i_rec_two_stage_fault_flag & i_rec_s1_walk;
      default: ipa_ok = 1'b0;
    endcase
  end

  // =====================================================================
  // syndrome 0: a record event wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      synd0_q <= sfsr_pkg::RST_SYND;
    end
    else if (rec_fire)
    begin
      synd0_q <= synd0_d;
    end
    else if (wr_fire && i_avs_address == sfsr_pkg::OFF_SYND0)
    begin
      // unsupported two-stage fields and bit 7 keep their value
      synd0_q <= (be_merge(synd0_q, i_avs_writedata, i_avs_byteenable) & SYND0_WMASK & (BIX_KEEP | ~(32'h0000_00ff << sfsr_pkg::BIX_LSB))) | (synd0_q & ~SYND0_WMASK);
    end
  end

  // syndrome 1: layout is free, kept as plain software storage
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      synd1_q <= sfsr_pkg::RST_SYND;
    end
    else if (wr_fire && i_avs_address == sfsr_pkg::OFF_SYND1)
    begin
      synd1_q <= be_merge(synd1_q, i_avs_writedata, i_avs_byteenable);
    end
  end

  // ipa register, captured with the syndrome from the same event
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ipa_q <= sfsr_pkg::RST_IPA;
    end
    else if (rec_fire)
    begin
      ipa_q <= i_rec_ipa & FAULTING_IPA_FIELD_MASK;
    end
    else if (wr_fire && TWO_STAGE_FAULT_FLAG_SUPP && i_avs_address == sfsr_pkg::OFF_IPA_LO)
    begin
      ipa_q[31:0] <= be_merge(ipa_q[31:0], i_avs_writedata, i_avs_byteenable) & FAULTING_IPA_FIELD_MASK[31:0];
    end
    else if (wr_fire && TWO_STAGE_FAULT_FLAG_SUPP && i_avs_address == sfsr_pkg::OFF_IPA_HI)
    begin
      ipa_q[63:32] <= be_merge(ipa_q[63:32], i_avs_writedata, i_avs_byteenable) & FAULTING_IPA_FIELD_MASK[63:32];
    end
  end

  // record enable, lets software freeze the captured fault while it inspects it
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rec_en_q <= sfsr_pkg::RST_REC_EN;
    end
    else if (wr_fire && i_avs_address == sfsr_pkg::OFF_CTRL && i_avs_byteenable[0])
    begin
      rec_en_q <= i_avs_writedata[sfsr_pkg::POS_REC_EN];
    end
  end

  // status flags: record valid set and ipa valid loaded with ipa_ok on record, cleared by writing one, record wins
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rec_valid_q <= 1'b0;
      ipa_valid_q <= 1'b0;
    end
    else if (rec_fire)
    begin
      rec_valid_q <= 1'b1;
      ipa_valid_q <= ipa_ok;
    end
    else if (wr_fire && i_avs_address == sfsr_pkg::OFF_STATUS && i_avs_byteenable[0] &&
             i_avs_writedata[sfsr_pkg::POS_REC_VALID])
    begin
      rec_valid_q <= 1'b0;
      ipa_valid_q <= 1'b0;
    end
  end

  assign o_rec_valid = rec_valid_q;
  assign o_ipa_valid = ipa_valid_q;

  // =====================================================================
  // read data, registered in the wait cycle
  assign ipa_view = TWO_STAGE_FAULT_FLAG_SUPP ? ipa_q : (i_far & FAULTING_IPA_FIELD_MASK);

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_avs_readdata <= 32'h0000_0000;
    end
    else if (rd_fire)
    begin
      unique case (i_avs_address)
        sfsr_pkg::OFF_SYND0:  o_avs_readdata <= synd0_q;
        sfsr_pkg::OFF_SYND1:  o_avs_readdata <= synd1_q;
        sfsr_pkg::OFF_IPA_LO: o_avs_readdata <= ipa_view[31:0];
        sfsr_pkg::OFF_IPA_HI: o_avs_readdata <= ipa_view[63:32];
        sfsr_pkg::OFF_CTRL:   o_avs_readdata <= {31'h0000_0000, rec_en_q};
        sfsr_pkg::OFF_STATUS: o_avs_readdata <= {30'h0000_0000, ipa_valid_q, rec_valid_q};
        default:              o_avs_readdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // =====================================================================
  // checks
  property p_bank_idx;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire |=> synd0_q[23:16] == (TWO_STAGE_FAULT_FLAG_SUPP && $past(i_rec_two_stage_fault_flag) ?
                 ($past(i_rec_bank_idx) & BIX_KEEP[23:16]) : 8'h00);
  endproperty
  a_bank_idx: assert property (p_bank_idx) else $error("bank index not recorded");

  property p_no_nest;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !TWO_STAGE_FAULT_FLAG_SUPP |-> synd0_q[23:16] == 8'h00 && !synd0_q[2] && !synd0_q[3];
  endproperty
  a_no_nest: assert property (p_no_nest) else $error("two-stage field set without support");

  property p_async;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire |=> synd0_q[11] == $past(i_rec_async) && synd0_q[8] == $past(i_rec_nonsecure);
  endproperty
  a_async: assert property (p_async) else $error("async or nonsecure flag wrong");

  property p_walk_ext;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire && !(i_rec_in_walk && i_rec_kind == sfsr_pkg::FK_EXTERNAL) |=> !synd0_q[10];
  endproperty
  a_walk_ext: assert property (p_walk_ext) else $error("walk external flag set wrongly");

  property p_bit7;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !synd0_q[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("bit 7 changed");

  property p_atomic;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire && i_rec_atomic && i_rec_miss_rd |=> !synd0_q[4];
  endproperty
  a_atomic: assert property (p_atomic) else $error("atomic write flag wrong");

  property p_level;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire |=> synd0_q[1:0] == $past(i_rec_level);
  endproperty
  a_level: assert property (p_level) else $error("table level wrong");

  property p_alias;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rd_fire && !TWO_STAGE_FAULT_FLAG_SUPP && i_avs_address == sfsr_pkg::OFF_IPA_LO |=>
      o_avs_readdata == ($past(i_far[31:0]) & FAULTING_IPA_FIELD_MASK[31:0]);
  endproperty
  a_alias: assert property (p_alias) else $error("ipa alias wrong");

  property p_ipa_perm;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire && i_rec_kind == sfsr_pkg::FK_PERMISSION && !i_rec_perm_fault |=> !o_ipa_valid;
  endproperty
  a_ipa_perm: assert property (p_ipa_perm) else $error("ipa valid for plain permission fault");

  property p_mask;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (ipa_q & ~FAULTING_IPA_FIELD_MASK) == 64'h0000_0000_0000_0000;
  endproperty
  a_mask: assert property (p_mask) else $error("ipa bits outside field");

  property p_together;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    rec_fire |=> o_rec_valid && ipa_q == ($past(i_rec_ipa) & FAULTING_IPA_FIELD_MASK) && synd0_q[2] == (TWO_STAGE_FAULT_FLAG_SUPP & $past(i_rec_two_stage_fault_flag));
  endproperty
  a_together: assert property (p_together) else $error("record not atomic");

endmodule

/* File: rtl/sfsr_pkg.sv */
package sfsr_pkg;

  // =====================================================================
  // register byte offsets on the avalon slave
  localparam logic [4:0] OFF_SYND0   = 5'h00;
  localparam logic [4:0] OFF_SYND1   = 5'h04;
  localparam logic [4:0] OFF_IPA_LO  = 5'h08;
  localparam logic [4:0] OFF_IPA_HI  = 5'h0c;
  localparam logic [4:0] OFF_CTRL    = 5'h10;
  localparam logic [4:0] OFF_STATUS  = 5'h14;

  // =====================================================================
  // syndrome 0 field positions
  localparam int BIX_LSB      = 16;
  localparam int BIX_FULL_W   = 8;
  localparam int POS_ASYNC    = 11;
  localparam int POS_WALK_EXT = 10;
  localparam int POS_ADDR_OP  = 9;
  localparam int POS_NONSEC   = 8;
  localparam int POS_UNK7     = 7;
  localparam int POS_INSTR    = 6;
  localparam int POS_PRIV     = 5;
  localparam int POS_WRITE    = 4;
  localparam int POS_S1_WALK  = 3;
  localparam int POS_TWO_STAGE_FAULT_FLAG   = 2;
  localparam int LVL_LSB      = 0;
  localparam int LVL_W        = 2;

  // control and status bits
  localparam int POS_REC_EN    = 0;
  localparam int POS_REC_VALID = 0;
  localparam int POS_IPA_VALID = 1;

  // =====================================================================
  // reset values (architecturally unknown; syndrome and ipa held at zero here, recording enabled)
  localparam logic [31:0] RST_SYND  = 32'h0000_0000;
  localparam logic [63:0] RST_IPA   = 64'h0000_0000_0000_0000;
  localparam logic        RST_REC_EN = 1'b1;

  // granule low bounds of the fault address field
  localparam int LOW_4K  = 12;
  localparam int LOW_16K = 14;
  localparam int LOW_64K = 16;

  // kind of fault being recorded
  typedef enum logic [2:0] {
    FK_TRANSLATION,
    FK_ACCESS,
    FK_EXTERNAL,
    FK_ADDR_SIZE,
    FK_PERMISSION,
    FK_OTHER
  } sfsr_kind_type;

endpackage

/* File: sim/sfsr_record_tb.sv */
module sfsr_record_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // one fault record with the syndrome and ipa validity it should leave
  typedef struct {
    sfsr_pkg::sfsr_kind_type kind;
    logic [12:0]             f;
    logic [7:0]              bix;
    logic [1:0]              lvl;
    logic [63:0]             ipa;
    logic [31:0]             exp_s0;
    logic                    exp_iv;
  } sfsr_row_type;

  // default build keeps ipa bits [47:12] only
  localparam logic [63:0] IPA_MASK = 64'h0000_ffff_ffff_f000;

  logic                    clk;
  logic                    rstn;
  logic [4:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic                    rec_valid;
  sfsr_pkg::sfsr_kind_type rec_kind;
  logic [12:0]             rec_f;
  logic [7:0]              rec_bix;
  logic [1:0]              rec_lvl;
  logic [63:0]             rec_ipa;
  logic [63:0]             far_val;
  logic                    rec_flag;
  logic                    ipa_flag;
  logic [31:0]             avs_readdata_flat;
  logic                    waitreq_flat;
  logic                    rec_flag_flat;
  logic                    ipa_flag_flat;
  logic [31:0]             q_flat;
  logic [31:0]             q;
  int                      n_fail;
  int                      samples_checked;
  sfsr_row_type            rows [8];

  sfsr_record dut (
    .i_clk_sys         (clk),
    .i_rstn            (rstn),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .i_avs_byteenable  (avs_byteenable),
    .o_avs_readdata    (avs_readdata),
    .o_avs_waitrequest (avs_waitrequest),
    .i_rec_valid       (rec_valid),
    .i_rec_kind        (rec_kind),
    .i_rec_two_stage_fault_flag      (rec_f[12]),
    .i_rec_bank_idx    (rec_bix),
    .i_rec_async       (rec_f[11]),
    .i_rec_in_walk     (rec_f[10]),
    .i_rec_addr_op     (rec_f[9]),
    .i_rec_nonsecure   (rec_f[8]),
    .i_rec_instr       (rec_f[7]),
    .i_rec_priv        (rec_f[6]),
    .i_rec_write       (rec_f[5]),
    .i_rec_atomic      (rec_f[4]),
    .i_rec_miss_rd     (rec_f[3]),
    .i_rec_miss_wr     (rec_f[2]),
    .i_rec_s1_walk     (rec_f[1]),
    .i_rec_perm_fault  (rec_f[0]),
    .i_rec_level       (rec_lvl),
    .i_rec_ipa         (rec_ipa),
    .i_far             (far_val),
    .o_rec_valid       (rec_flag),
    .o_ipa_valid       (ipa_flag)
  );

  // second build without two-stage support, fed by the same stimulus
  sfsr_record #(
    .TWO_STAGE_FAULT_FLAG_SUPP (1'b0)
  ) dut_flat (
    .i_clk_sys         (clk),
    .i_rstn            (rstn),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .i_avs_byteenable  (avs_byteenable),
    .o_avs_readdata    (avs_readdata_flat),
    .o_avs_waitrequest (waitreq_flat),
    .i_rec_valid       (rec_valid),
    .i_rec_kind        (rec_kind),
    .i_rec_two_stage_fault_flag      (rec_f[12]),
    .i_rec_bank_idx    (rec_bix),
    .i_rec_async       (rec_f[11]),
    .i_rec_in_walk     (rec_f[10]),
    .i_rec_addr_op     (rec_f[9]),
    .i_rec_nonsecure   (rec_f[8]),
    .i_rec_instr       (rec_f[7]),
    .i_rec_priv        (rec_f[6]),
    .i_rec_write       (rec_f[5]),
    .i_rec_atomic      (rec_f[4]),
    .i_rec_miss_rd     (rec_f[3]),
    .i_rec_miss_wr     (rec_f[2]),
    .i_rec_s1_walk     (rec_f[1]),
    .i_rec_perm_fault  (rec_f[0]),
    .i_rec_level       (rec_lvl),
    .i_rec_ipa         (rec_ipa),
    .i_far             (far_val),
    .o_rec_valid       (rec_flag_flat),
    .o_ipa_valid       (ipa_flag_flat)
  );

  // ==========================================================================
  // clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================================
  // avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 16)
    begin
      n++;
      @(posedge clk);
    end
    q = avs_readdata;
    q_flat = avs_readdata_flat;
    chk(waitreq_flat, 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 16)
    begin
      n_fail++;
      $display("ERROR t=%0t bus answer timed out", $time);
      test_done();
    end
    // one idle edge so the next request never lands in the same step
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(q, exp);
  endtask

  // presents one record for one cycle; the caller drops the strobe
  task automatic drv(input sfsr_row_type r);
    rec_kind  <= r.kind;
    rec_f     <= r.f;
    rec_bix   <= r.bix;
    rec_lvl   <= r.lvl;
    rec_ipa   <= r.ipa;
    rec_valid <= 1'b1;
    @(posedge clk);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    rec_valid = 1'b0;
    rec_kind = sfsr_pkg::FK_OTHER;
    rec_f = 13'h0000;
    rec_bix = 8'h00;
    rec_lvl = 2'h0;
    rec_ipa = 64'h0000_0000_0000_0000;
    far_val = 64'h0000_0000_5555_a000;
    rows[0] = '{sfsr_pkg::FK_TRANSLATION, 13'h1160, 8'h5a, 2'h1, 64'hffff_1234_5678_9abc, 32'h005a_0135, 1'b1};
    rows[1] = '{sfsr_pkg::FK_EXTERNAL, 13'h0c80, 8'h33, 2'h0, 64'h0000_0001_2345_6fff, 32'h0000_0c40, 1'b1};
    rows[2] = '{sfsr_pkg::FK_ACCESS, 13'h0700, 8'h00, 2'h3, 64'h0000_abcd_ef01_2345, 32'h0000_0303, 1'b1};
    rows[3] = '{sfsr_pkg::FK_ADDR_SIZE, 13'h00c0, 8'h00, 2'h2, 64'h8000_0000_0000_1000, 32'h0000_0062, 1'b1};
    rows[4] = '{sfsr_pkg::FK_PERMISSION, 13'h1017, 8'h01, 2'h3, 64'h0000_7777_8888_9999, 32'h0001_001f, 1'b1};
    rows[5] = '{sfsr_pkg::FK_PERMISSION, 13'h103d, 8'hff, 2'h1, 64'h0000_0000_0000_0000, 32'h00ff_0005, 1'b0};
    rows[6] = '{sfsr_pkg::FK_OTHER, 13'h0120, 8'h00, 2'h0, 64'h0000_0000_0000_0000, 32'h0000_0110, 1'b0};
    rows[7] = '{sfsr_pkg::FK_PERMISSION, 13'h1002, 8'h00, 2'h2, 64'h0000_0000_0000_0000, 32'h0000_000e, 1'b0};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // reset state
    chk(rec_flag, 1'b0);
    chk(ipa_flag, 1'b0);
    chk(avs_waitrequest, 1'b0);
    rd(sfsr_pkg::OFF_SYND0, sfsr_pkg::RST_SYND[31:0]);
    rd(sfsr_pkg::OFF_CTRL, 32'h0000_0001);
    $display("test reset done");
    // table of records: every kind and level code, with eight chosen flag settings
    for (int i = 0; i < 8; i++)
    begin
      drv(rows[i]);
      rec_valid <= 1'b0;
      @(posedge clk);
      chk(rec_flag, 1'b1);
      chk(ipa_flag, rows[i].exp_iv);
      chk(rec_flag_flat, 1'b1);
      chk(ipa_flag_flat, rows[i].exp_iv && rows[i].kind != sfsr_pkg::FK_PERMISSION);
      rd(sfsr_pkg::OFF_SYND0, rows[i].exp_s0);
      // without two-stage support the bank index, walk and two_stage_fault_flag bits read zero
      chk(q_flat, rows[i].exp_s0 & 32'hff00_fff3);
      rd(sfsr_pkg::OFF_STATUS, {30'h0, rows[i].exp_iv, 1'b1});
      if (rows[i].exp_iv)
      begin
        rd(sfsr_pkg::OFF_IPA_LO, rows[i].ipa[31:0] & IPA_MASK[31:0]);
        rd(sfsr_pkg::OFF_IPA_HI, rows[i].ipa[63:32] & IPA_MASK[63:32]);
      end
    end
    $display("test record table done");
    // back to back records: the later one wins whole, never a mixture
    drv(rows[0]);
    drv(rows[2]);
    rec_valid <= 1'b0;
    @(posedge clk);
    rd(sfsr_pkg::OFF_SYND0, rows[2].exp_s0);
    rd(sfsr_pkg::OFF_IPA_LO, rows[2].ipa[31:0] & IPA_MASK[31:0]);
    rd(sfsr_pkg::OFF_IPA_HI, rows[2].ipa[63:32] & IPA_MASK[63:32]);
    $display("test back to back done");
    // clear the status flags from software
    wr(sfsr_pkg::OFF_STATUS, 32'h0000_0001, 4'hf);
    chk(rec_flag, 1'b0);
    chk(ipa_flag, 1'b0);
    // recording disabled: a record must leave everything alone
    wr(sfsr_pkg::OFF_CTRL, 32'h0000_0000, 4'hf);
    drv(rows[0]);
    rec_valid <= 1'b0;
    @(posedge clk);
    chk(rec_flag, 1'b0);
    rd(sfsr_pkg::OFF_SYND0, rows[2].exp_s0);
    $display("test disabled record done");
    // software access: reserved and unknown bits drop, storage bits stick
    wr(sfsr_pkg::OFF_SYND0, 32'hffff_ffff, 4'hf);
    rd(sfsr_pkg::OFF_SYND0, 32'h00ff_0f7f);
    chk(q_flat, 32'h0000_0f73);
    wr(sfsr_pkg::OFF_SYND1, 32'hdead_beef, 4'hf);
    rd(sfsr_pkg::OFF_SYND1, 32'hdead_beef);
    wr(sfsr_pkg::OFF_SYND1, 32'h0000_0011, 4'h1);
    rd(sfsr_pkg::OFF_SYND1, 32'hdead_be11);
    wr(sfsr_pkg::OFF_IPA_LO, 32'hffff_ffff, 4'hf);
    rd(sfsr_pkg::OFF_IPA_LO, 32'hffff_f000);
    chk(q_flat, far_val[31:0] & IPA_MASK[31:0]);
    wr(sfsr_pkg::OFF_IPA_HI, 32'hffff_ffff, 4'hf);
    rd(sfsr_pkg::OFF_IPA_HI, 32'h0000_ffff);
    chk(q_flat, far_val[63:32] & IPA_MASK[63:32]);
    wr(5'h18, 32'hffff_ffff, 4'hf);
    rd(5'h18, 32'h0000_0000);
    $display("test software access done");
    // reset in mid-run brings back the enable and clears the flags
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(rec_flag, 1'b0);
    rd(sfsr_pkg::OFF_CTRL, 32'h0000_0001);
    $display("test second reset done");
    test_done();
  end

endmodule
